/* File: rtl/nfi_top.sv */
`timescale 1ns/1ps
// Functional notes
// - eight physical fault channels each sit in one serial link.
// - each physical channel carries a software-set logical channel number.
// - failing a logical channel moves all its physical channels in one cycle.
// - states are pass-through, stuck low and stuck high.
// - each channel indicator is green for pass, dark for low, red for high.
// - both connector sides of a channel get the same fault state.
// - a sync output tells the processor the host is ready.
// - each sync has an indicator, red for stop and green for run.
// - the timebase tick is local or external, selectable.
// - a 24-bit experiment timer and a fault delay timer exist.
// - timebase, syncs and controls go out on the experiment bus.
module nfi_top (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [nfi_pkg::NUM_PHYS-1:0] i_link_in,
    input wire logic [nfi_pkg::NUM_PHYS-1:0] i_link_out_side,
    output logic [nfi_pkg::NUM_PHYS-1:0] o_link_in_side,
    output logic [nfi_pkg::NUM_PHYS-1:0] o_link_out,
    output logic [2*nfi_pkg::NUM_PHYS-1:0] o_chan_led,
    input wire logic i_map_we,
    input wire logic [2:0] i_map_phys,
    input wire logic [nfi_pkg::LOG_W-1:0] i_map_log,
    input wire logic i_fault_cmd,
    input wire logic [nfi_pkg::LOG_W-1:0] i_fault_log,
    input wire logic [1:0] i_fault_state,
    input wire logic [nfi_pkg::TIMER_W-1:0] i_fault_delay,
    output logic o_fault_pending,
    input wire logic i_host_ready,
    output logic o_host_ready_sync_out,
    input wire logic i_proc_sync,
    output logic [1:0] o_sync_out_led,
    output logic [1:0] o_sync_in_led,
    input wire logic i_tb_sel_ext,
    input wire logic i_ext_tick,
    input wire logic [nfi_pkg::TIMER_W-1:0] i_tick_div,
    input wire logic i_exp_timer_clr,
    output logic [nfi_pkg::TIMER_W-1:0] o_exp_time,
    output logic o_xbus_tick,
    output logic o_xbus_sync_out,
    output logic o_xbus_sync_in,
    output logic o_xbus_run
);
    // channel map and the waiting fault command
    logic [nfi_pkg::LOG_W-1:0] chan_map [nfi_pkg::NUM_PHYS];
    logic [nfi_pkg::NUM_PHYS-1:0] hit;
    logic apply_now;
    logic next_pending;
    logic [nfi_pkg::TIMER_W-1:0] next_delay_cnt;
    nfi_pkg::nfi_state_t pend_state;
    logic [nfi_pkg::LOG_W-1:0] pend_log;
    logic [nfi_pkg::TIMER_W-1:0] delay_cnt;
    logic [nfi_pkg::TIMER_W-1:0] div_cnt;
    // timebase and experiment time
    logic ext_tick_q;
    logic ext_rise;
    logic [nfi_pkg::TIMER_W-1:0] next_div_cnt;
    logic [nfi_pkg::TIMER_W-1:0] next_exp_time;
    logic local_tick;
    logic tick;
    logic delay_done;
    logic running;
    nfi_pkg::nfi_state_t cmd_state;

    nfi_chan_if cif ();

    // state code decode; the spare code 3 falls back to pass, the safe choice
    function automatic nfi_pkg::nfi_state_t decode_state(input logic [1:0] code);
        unique case (code)
            2'h1: decode_state = nfi_pkg::NFI_STUCK_LO;
            2'h2: decode_state = nfi_pkg::NFI_STUCK_HI;
            default: decode_state = nfi_pkg::NFI_PASS;
        endcase
    endfunction : decode_state

    // sync indicator: red while the line means stop, green while it means run
    function automatic logic [1:0] sync_led(input logic run);
        sync_led = run ? nfi_pkg::LED_GREEN : nfi_pkg::LED_RED;
    endfunction : sync_led

    // command decode and delay expiry
    assign cmd_state = decode_state(i_fault_state);
    assign delay_done = o_fault_pending && (delay_cnt == nfi_pkg::TIMER_RST);
    // a command landing in the expiry cycle restarts the wait, so nothing applies then
    assign apply_now = delay_done && !i_fault_cmd;

    // a new command wins over the expiry of an older one in the same cycle
    assign next_pending = i_fault_cmd || (o_fault_pending && !delay_done);
    // loaded by a command, then counted down in clock cycles while it waits
    assign next_delay_cnt = i_fault_cmd ? i_fault_delay :
        (o_fault_pending && !delay_done) ? delay_cnt - 24'h000001 : delay_cnt;

    // channels that answer to the pending logical number all move together
    for (genvar g = 0; g < nfi_pkg::NUM_PHYS; g++)
    begin : g_hit
        assign hit[g] = (chan_map[g] == pend_log);
    end

    // experiment runs only while both syncs say run
    assign running = o_host_ready_sync_out && i_proc_sync;

    // timebase select: external tick edge or local divider
    assign local_tick = (div_cnt == nfi_pkg::TIMER_RST);
    // the edge flop resets low, the idle level of the outside tick, so no false edge
    assign ext_rise = i_ext_tick && !ext_tick_q;
    assign tick = i_tb_sel_ext ? ext_rise : local_tick;
    // the divider reloads on its own tick, so the period is the reload value plus one
    assign next_div_cnt = local_tick ? i_tick_div : div_cnt - 24'h000001;
    // a clear beats a tick in the same cycle; time moves only while both syncs run
    assign next_exp_time = i_exp_timer_clr ? nfi_pkg::TIMER_RST :
        (tick && running) ? o_exp_time + 24'h000001 : o_exp_time;

    // physical to logical map, written one entry at a time
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            for (int i = 0; i < nfi_pkg::NUM_PHYS; i++)
                chan_map[i] <= nfi_pkg::MAP_RST;
        else if (i_ce && i_map_we)
            chan_map[i_map_phys] <= i_map_log;
    end

    // fault command held pending, delay timer counts clock cycles down
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_fault_pending <= 1'b0;
            pend_state <= nfi_pkg::NFI_PASS;
            pend_log <= nfi_pkg::MAP_RST;
            delay_cnt <= nfi_pkg::TIMER_RST;
        end
        else if (i_ce)
        begin
            o_fault_pending <= next_pending;
            delay_cnt <= next_delay_cnt;
            if (i_fault_cmd)
            begin
                pend_state <= cmd_state;
                pend_log <= i_fault_log;
            end
        end
    end

    // apply to every mapped channel in the same cycle
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            for (int i = 0; i < nfi_pkg::NUM_PHYS; i++)
                cif.state[i] <= nfi_pkg::NFI_PASS;
        else if (i_ce && apply_now)
            for (int i = 0; i < nfi_pkg::NUM_PHYS; i++)
                if (hit[i])
                    cif.state[i] <= pend_state;
    end

    // experiment timer and timebase divider
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            div_cnt <= nfi_pkg::TIMER_RST;
            ext_tick_q <= 1'b0;
            o_exp_time <= nfi_pkg::TIMER_RST;
            o_xbus_tick <= 1'b0;
        end
        else if (i_ce)
        begin
            ext_tick_q <= i_ext_tick;
            div_cnt <= next_div_cnt;
            o_xbus_tick <= tick;
            o_exp_time <= next_exp_time;
        end
    end

    // syncs, indicators and experiment bus
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_host_ready_sync_out <= 1'b0;
            o_sync_out_led <= nfi_pkg::LED_RED;
            o_sync_in_led <= nfi_pkg::LED_RED;
        end
        else if (i_ce)
        begin
            o_host_ready_sync_out <= i_host_ready;
            o_sync_out_led <= sync_led(i_host_ready);
            o_sync_in_led <= sync_led(i_proc_sync);
        end
    end

    // experiment bus copies, registered so every board sees them on the same edge
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_xbus_sync_out <= 1'b0;
            o_xbus_sync_in <= 1'b0;
            o_xbus_run <= 1'b0;
        end
        else if (i_ce)
        begin
            o_xbus_sync_out <= i_host_ready;
            o_xbus_sync_in <= i_proc_sync;
            o_xbus_run <= running;
        end
    end

    nfi_channels u_chan (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .ch(cif.chan),
        .i_link_in(i_link_in),
        .i_link_out_side(i_link_out_side),
        .o_link_in_side(o_link_in_side),
        .o_link_out(o_link_out),
        .o_chan_led(o_chan_led)
    );
endmodule : nfi_top

/* File: rtl/nfi_pkg.sv */
package nfi_pkg;
    // channel counts and widths
    localparam int NUM_PHYS = 8;
    localparam int NUM_LOG = 8;
    localparam int LOG_W = 3;
    localparam int TIMER_W = 24;
    // fault states
    typedef enum logic [1:0] {NFI_PASS, NFI_STUCK_LO, NFI_STUCK_HI} nfi_state_t;
    // indicator encoding {red, green}
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED = 2'h2;
    localparam logic [1:0] LED_OFF = 2'h0;
    // reset values
    localparam logic [TIMER_W-1:0] TIMER_RST = 24'h000000;
    localparam logic [LOG_W-1:0] MAP_RST = 3'h0;
endpackage : nfi_pkg

/* File: rtl/nfi_chan_if.sv */
`timescale 1ns/1ps
// per-channel state travelling from the controller to the channel logic
interface nfi_chan_if;
    nfi_pkg::nfi_state_t state [nfi_pkg::NUM_PHYS];
    modport ctrl (output state);
    modport chan (input state);
endinterface : nfi_chan_if

/* File: rtl/nfi_channels.sv */
`timescale 1ns/1ps
// applies each channel's fault state to its link and indicator
module nfi_channels (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_ce,
    nfi_chan_if.chan ch,
    input wire logic [nfi_pkg::NUM_PHYS-1:0] i_link_in,
    input wire logic [nfi_pkg::NUM_PHYS-1:0] i_link_out_side,
    output logic [nfi_pkg::NUM_PHYS-1:0] o_link_in_side,
    output logic [nfi_pkg::NUM_PHYS-1:0] o_link_out,
    output logic [2*nfi_pkg::NUM_PHYS-1:0] o_chan_led
);
    logic [nfi_pkg::NUM_PHYS-1:0] fwd;
    logic [nfi_pkg::NUM_PHYS-1:0] rev;
    logic [2*nfi_pkg::NUM_PHYS-1:0] led;

    function automatic logic apply(input nfi_pkg::nfi_state_t s, input logic d);
        unique case (s)
            nfi_pkg::NFI_PASS: apply = d;
            nfi_pkg::NFI_STUCK_LO: apply = 1'b0;
            nfi_pkg::NFI_STUCK_HI: apply = 1'b1;
            default: apply = d;
        endcase
    endfunction : apply

    // both connector directions see the same state
    genvar g;
    for (g = 0; g < nfi_pkg::NUM_PHYS; g++)
    begin : g_ch
        assign fwd[g] = apply(ch.state[g], i_link_in[g]);
        assign rev[g] = apply(ch.state[g], i_link_out_side[g]);
        assign led[2*g+1:2*g] = (ch.state[g] == nfi_pkg::NFI_PASS) ? nfi_pkg::LED_GREEN :
            (ch.state[g] == nfi_pkg::NFI_STUCK_HI) ? nfi_pkg::LED_RED : nfi_pkg::LED_OFF;
    end

    // registered outputs add one cycle of link latency
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_link_out <= '0;
            o_link_in_side <= '0;
            o_chan_led <= {nfi_pkg::NUM_PHYS{nfi_pkg::LED_GREEN}};
        end
        else if (i_ce)
        begin
            o_link_out <= fwd;
            o_link_in_side <= rev;
            o_chan_led <= led;
        end
    end
endmodule : nfi_channels

/* File: verif/nfi_monitor.sv */
`timescale 1ns/1ps
// port-level checks on the fault channels, syncs and experiment time
module nfi_monitor (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic [7:0] i_link_in,
    input wire logic [7:0] i_link_out_side,
    input wire logic [7:0] o_link_in_side,
    input wire logic [7:0] o_link_out,
    input wire logic [15:0] o_chan_led,
    input wire logic i_fault_cmd,
    input wire logic o_fault_pending,
    input wire logic i_host_ready,
    input wire logic i_proc_sync,
    input wire logic [1:0] o_sync_out_led,
    input wire logic [1:0] o_sync_in_led,
    input wire logic [23:0] o_exp_time
);
    localparam logic [1:0] GRN = nfi_pkg::LED_GREEN;
    localparam logic [1:0] RED = nfi_pkg::LED_RED;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // indicator and both link sides always agree on one state
    for (genvar i = 0; i < 8; i++)
    begin : g_ch
        AST_PASS: assert property (!$past(i_srst) && $past(i_ce)
            && o_chan_led[2*i+:2] == GRN
            |-> o_link_out[i] == $past(i_link_in[i]) && o_link_in_side[i] == $past(i_link_out_side[i]))
            else $error("pass channel not copying");
        AST_HIGH: assert property (o_chan_led[2*i+:2] == RED |-> o_link_out[i] && o_link_in_side[i])
            else $error("red channel not high");
        AST_LOW: assert property (o_chan_led[2*i+:2] == 2'h0 |-> !(o_link_out[i] | o_link_in_side[i]))
            else $error("dark channel not low");
    end
    AST_RST: assert property ($past(i_srst) |-> o_chan_led == {8{GRN}} && o_sync_out_led == RED && !o_fault_pending)
        else $error("reset state wrong");
    AST_OUT_RUN: assert property (i_host_ready [*3] |=> o_sync_out_led == GRN)
        else $error("sync out led not green");
    AST_OUT_STOP: assert property (!i_host_ready [*3] |=> o_sync_out_led == RED)
        else $error("sync out led not red");
    AST_IN_RUN: assert property (i_proc_sync [*4] |=> o_sync_in_led == GRN)
        else $error("sync in led not green");
    AST_PEND: assert property ($rose(o_fault_pending) |-> $past(i_fault_cmd))
        else $error("pending without command");
    AST_TIME: assert property (!$stable(o_exp_time) |-> o_exp_time == $past(o_exp_time) + 24'h000001 || o_exp_time == 24'h000000)
        else $error("time jumped");
    cover property ($rose(o_fault_pending));
    cover property (o_chan_led[1:0] == RED);
    cover property (o_exp_time == 24'h000010);
endmodule : nfi_monitor

/* File: verif/nfi_partner.sv */
`timescale 1ns/1ps
// processor side; link data changes every cycle so a stuck output shows
module nfi_partner (
    input wire logic i_mclk,
    input wire logic i_run,
    output logic [7:0] o_link_in,
    output logic [7:0] o_link_out_side,
    output logic o_proc_sync = 1'b0,
    output logic o_ext_tick
);
    logic [7:0] cnt = 8'h00;
    // changes land just after the edge, like any outside driver
    always @(posedge i_mclk)
    begin
        cnt <= #1 cnt + 8'h01;
        o_proc_sync <= #1 i_run;
    end
    assign o_link_in = cnt;
    assign o_link_out_side = ~cnt;
    assign o_ext_tick = cnt[2]; // one rising edge every 8 cycles
endmodule : nfi_partner

/* File: verif/nfi_top_tb.sv */
`timescale 1ns/1ps
// the partner plays the processor; the bench drives fault and timebase controls
module nfi_top_tb;
    logic i_mclk = 1'b0, i_srst = 1'b1, i_ce = 1'b1, i_map_we = 1'b0, i_fault_cmd = 1'b0;
    logic i_host_ready = 1'b0, i_tb_sel_ext = 1'b0, i_exp_timer_clr = 1'b0, run = 1'b0;
    logic [2:0] i_map_phys = 3'h0, i_map_log = 3'h0, i_fault_log = 3'h0;
    logic [1:0] i_fault_state = 2'h0, o_sync_out_led, o_sync_in_led, lv;
    logic [23:0] i_fault_delay = 24'h000000, i_tick_div = 24'h000004, t0, o_exp_time, nt;
    logic [7:0] i_link_in, i_link_out_side, o_link_in_side, o_link_out, lin, lrev;
    logic [15:0] o_chan_led;
    logic i_proc_sync, i_ext_tick, o_fault_pending, o_host_ready_sync_out;
    logic o_xbus_tick, o_xbus_sync_out, o_xbus_sync_in, o_xbus_run;
    int miscompares = 0, comparisons = 0;
    nfi_top uut (.*);
    nfi_partner prt (.i_mclk(i_mclk), .i_run(run), .o_link_in(i_link_in),
        .o_link_out_side(i_link_out_side), .o_proc_sync(i_proc_sync), .o_ext_tick(i_ext_tick));
    always #5 i_mclk = ~i_mclk;
    task cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc
    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task cmd(input logic [2:0] lg, input logic [1:0] st, input logic [23:0] d);
        i_fault_cmd = 1'b1;
        i_fault_log = lg;
        i_fault_state = st;
        i_fault_delay = d;
        cyc(1);
        i_fault_cmd = 1'b0;
    endtask : cmd
    task t_reset;
        chk("chan led", o_chan_led, {8{nfi_pkg::LED_GREEN}});
        chk("sync", {o_host_ready_sync_out, o_sync_out_led}, 3'h2);
        $display("t_reset done");
    endtask : t_reset
    // even channels on logical 1, odd on logical 2, then every state code
    task t_modes;
        for (int p = 0; p < 8; p++)
        begin
            i_map_we = 1'b1;
            i_map_phys = p[2:0];
            i_map_log = p[0] ? 3'h2 : 3'h1;
            cyc(1);
        end
        i_map_we = 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            cmd(3'h1, s[1:0], 24'h000000);
            cyc(5);
            lv = s == 1 ? nfi_pkg::LED_OFF : s == 2 ? nfi_pkg::LED_RED : nfi_pkg::LED_GREEN;
            chk("chan led", o_chan_led, {4{2'h1, lv}});
            // pass copies what stood at the input one cycle earlier
            @(negedge i_mclk);
            lin = i_link_in;
            lrev = i_link_out_side;
            @(negedge i_mclk);
            chk("out", o_link_out & 8'h55,
                s == 2 ? 8'h55 : s == 1 ? 8'h00 : lin & 8'h55);
            chk("in side", o_link_in_side & 8'h55,
                s == 2 ? 8'h55 : s == 1 ? 8'h00 : lrev & 8'h55);
            chk("odd pass", o_link_out & 8'hAA, lin & 8'hAA);
            cyc(1);
        end
        $display("t_modes done");
    endtask : t_modes
    // a long delay holds the fault back; a newer command replaces a waiting one
    task t_delay;
        cmd(3'h2, 2'h2, 24'h000014);
        cyc(10);
        chk("held", {o_fault_pending, o_chan_led}, 17'h15555);
        cyc(20);
        chk("applied", {o_fault_pending, o_chan_led}, 17'h09999);
        cmd(3'h2, 2'h0, 24'h00001E);
        cyc(5);
        cmd(3'h2, 2'h1, 24'h000000);
        cyc(40);
        chk("replaced", o_chan_led, 16'h1111);
        $display("t_delay done");
    endtask : t_delay
    // both sync levels, out on the indicators and the experiment bus
    task t_sync;
        for (int r = 1; r >= 0; r--)
        begin
            i_host_ready = r[0];
            run = r[0];
            cyc(6);
            chk("ready", o_host_ready_sync_out, r[0]);
            chk("leds", {o_sync_out_led, o_sync_in_led}, r ? 4'h5 : 4'hA);
            chk("xbus", {o_xbus_sync_out, o_xbus_sync_in}, {2{r[0]}});
            chk("run", o_xbus_run, r[0]);
        end
        // local divider of 4 gives one bus tick every 5 cycles
        nt = 24'h000000;
        repeat (40)
        begin
            cyc(1);
            nt = nt + o_xbus_tick;
        end
        chk("xbus tick", nt, 24'h000008);
        $display("t_sync done");
    endtask : t_sync
    // local divider then external tick; time stands while a sync stops
    task t_time;
        i_host_ready = 1'b1;
        run = 1'b1;
        i_exp_timer_clr = 1'b1;
        cyc(4);
        chk("clear", o_exp_time, 24'h000000);
        i_exp_timer_clr = 1'b0;
        for (int e = 0; e < 2; e++)
        begin
            i_tb_sel_ext = e[0];
            cyc(16);
            t0 = o_exp_time;
            cyc(80);
            chk("ticks", o_exp_time - t0, e ? 24'h00000A : 24'h000010);
        end
        run = 1'b0;
        cyc(8);
        t0 = o_exp_time;
        cyc(40);
        chk("stopped", o_exp_time - t0, 24'h000000);
        // clock enable low freezes a running timer, which then resumes
        run = 1'b1;
        cyc(8);
        t0 = o_exp_time;
        i_ce = 1'b0;
        cyc(40);
        chk("frozen", o_exp_time - t0, 24'h000000);
        i_ce = 1'b1;
        cyc(40);
        chk("resumed", o_exp_time - t0, 24'h000005);
        $display("t_time done");
    endtask : t_time
    initial
    begin
        cyc(8);
        i_srst = 1'b0;
        cyc(1);
        t_reset;
        t_modes;
        t_delay;
        i_srst = 1'b1;
        cyc(2);
        i_srst = 1'b0;
        cyc(1);
        t_reset;
        t_sync;
        t_time;
        end_of_test;
    end
    // the tests need well under 1000 cycles
    initial
    begin
        #100000;
        miscompares++;
        end_of_test;
    end
endmodule : nfi_top_tb
bind nfi_top nfi_monitor mon (.*);
